// ==== design/scp_pkg.sv ====
// package: register map, field positions and timing constants of the serial configuration port
package scp_pkg;
    localparam int          SCP_ADDR_W          = 15;
    localparam logic [14:0] SCP_ADDR_IFCFG      = 15'h0000;
    localparam logic [14:0] SCP_ADDR_OUTMODE    = 15'h0561;
    localparam logic [7:0]  SCP_IFCFG_RST       = 8'h00;
    localparam logic [7:0]  SCP_OUTMODE_RST     = 8'h01;
    localparam logic [7:0]  SCP_SOFT_RST_VAL    = 8'h81;
    localparam int          SCP_BIT_SOFT_HI     = 7;
    localparam int          SCP_BIT_LSBF_HI     = 6;
    localparam int          SCP_BIT_LSBF_LO     = 1;
    localparam int          SCP_BIT_SOFT_LO     = 0;
    localparam logic [7:0]  SCP_IFCFG_WMASK     = 8'h66;
    localparam int          SCP_INSTR_BITS      = 16;
    localparam int          SCP_BYTE_BITS       = 8;
    localparam int          SCP_CLK_HZ          = 40_000_000;
    localparam int          SCP_RECOVER_MS      = 5;
    localparam int          SCP_RECOVER_CYC     = SCP_CLK_HZ / 1000 * SCP_RECOVER_MS;
endpackage : scp_pkg

// ==== design/scp_port.sv ====
// serial configuration port: three-wire link, register file and soft reset recovery
`timescale 1ns/1ps
// Summary of operation
// R1: three pins: serial clock in, one two-way data line, active-low select in.
// R2: reads and writes only happen while select is low.
// R3: frame starts on first rising serial clock after select falls.
// R4: select held low streams consecutive bytes indefinitely.
// R5: select may go high between bytes; frame context is kept (code keeps it only between the two instruction bytes).
// R6: select high leaves data line undriven (high impedance).
// R7: all transfers are eight-bit words.
// R8: first instruction bit picks read (1) or write (0).
// R9: on read, data line turns to output for the data phase.
// R10: MSB first after reset; configuration bits switch to LSB first.
// R11: clock and select are inputs only; data line is input while writing.
// R12: master writes unused bits of valid addresses as zero.
// R13: master never writes fully unassigned addresses.
// R14: any reset loads registers with their defaults.
// R15: writing 0x81 to address 0 resets; master waits 5 ms.
// R16: output mode register resets to 0x01, twos complement.
// R17: master avoids toggling port during critical sampling.
// R18: each address holds eight bits, bit 7 most significant.
// R19: interface config bits 6 and 1 mirror the LSB-first select.
// R20: fifteen address bits follow read/write bit; address increments per data byte.
module scp_port
    import scp_pkg::*;
#(
    parameter int RECOVER_CYC = SCP_RECOVER_CYC
) (
    input  wire logic       clk_i,
    input  wire logic       sys_rst_i,
    input  wire logic       sclk_i,
    input  wire logic       port_select_n_i,
    input  wire logic       sdio_i,
    output logic            sdio_o,
    output logic            sdio_oe_n_o,
    output logic [7:0]      output_format_mode_o,
    output logic            lsb_first_o,
    output logic            busy_o
);
    initial begin
        if (RECOVER_CYC < 1) begin
            $error("RECOVER_CYC must be at least 1");
        end
        if (SCP_INSTR_BITS != SCP_ADDR_W + 1) begin
            $error("instruction must be one direction bit plus the address");
        end
        if (SCP_BYTE_BITS != 8) begin
            $error("data words must be eight bits");
        end
        if (SCP_INSTR_BITS > 31) begin
            $error("bit counter too narrow for the instruction");
        end
        if (SCP_INSTR_BITS != 2 * SCP_BYTE_BITS) begin
            $error("instruction must be two whole bytes");
        end
    end

    // ---------------- system clock domain: registers ----------------
    logic [7:0]  interface_config_ff;
    logic [7:0]  output_format_mode_ff;
    logic [31:0] recover_cnt_ff;
    logic        rst_meta_ff;
    logic        rst_sync_ff;

    // link-side reset: level held by the system domain while resetting
    logic        link_rst_req;
    assign link_rst_req = sys_rst_i || (recover_cnt_ff != 32'h0000_0000);

    // write event crossing: toggle from link, data held stable
    logic        wr_tgl_ff;
    logic [14:0] wr_addr_ff;
    logic [7:0]  wr_data_ff;
    logic        wr_tgl_meta_ff;
    logic        wr_tgl_sync_ff;
    logic        wr_tgl_seen_ff;
    logic        wr_evt;
    assign wr_evt = wr_tgl_sync_ff ^ wr_tgl_seen_ff;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            wr_tgl_meta_ff <= 1'b0;
            wr_tgl_sync_ff <= 1'b0;
            wr_tgl_seen_ff <= 1'b0;
        end else begin
            wr_tgl_meta_ff <= wr_tgl_ff;
            wr_tgl_sync_ff <= wr_tgl_meta_ff;
            wr_tgl_seen_ff <= wr_tgl_sync_ff;
        end
    end

    logic soft_rst_hit;
    assign soft_rst_hit = wr_evt && (wr_addr_ff == SCP_ADDR_IFCFG)
                          && wr_data_ff[SCP_BIT_SOFT_HI] && wr_data_ff[SCP_BIT_SOFT_LO];

    // writes are dropped while the soft reset recovery runs
    logic       wr_accept;
    logic       ifcfg_wr_hit;
    logic       outmode_wr_hit;
    logic [7:0] ifcfg_wr_val;
    assign wr_accept      = wr_evt && (recover_cnt_ff == 32'h0000_0000);
    assign ifcfg_wr_hit   = wr_accept && (wr_addr_ff == SCP_ADDR_IFCFG);
    assign outmode_wr_hit = wr_accept && (wr_addr_ff == SCP_ADDR_OUTMODE);
    // soft reset bits self clear; mirrored order bits follow either copy
    assign ifcfg_wr_val   = (wr_data_ff[SCP_BIT_LSBF_HI] || wr_data_ff[SCP_BIT_LSBF_LO])
                            ? (SCP_IFCFG_WMASK & 8'h42) : SCP_IFCFG_RST;     // [R19]

    always_ff @(posedge clk_i) begin
        if (sys_rst_i || soft_rst_hit) begin
            interface_config_ff <= SCP_IFCFG_RST;                          // [R14] [R15]
        end else if (ifcfg_wr_hit) begin
            interface_config_ff <= ifcfg_wr_val;                           // [R19]
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i || soft_rst_hit) begin
            output_format_mode_ff <= SCP_OUTMODE_RST;                      // [R14] [R16]
        end else if (outmode_wr_hit) begin
            output_format_mode_ff <= wr_data_ff;                           // [R18]
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            recover_cnt_ff <= 32'h0000_0000;
        end else if (soft_rst_hit) begin
            recover_cnt_ff <= 32'(RECOVER_CYC);                            // [R15]
        end else if (recover_cnt_ff != 32'h0000_0000) begin
            recover_cnt_ff <= recover_cnt_ff - 32'h0000_0001;
        end
    end

    assign output_format_mode_o = output_format_mode_ff;
    assign lsb_first_o          = interface_config_ff[SCP_BIT_LSBF_LO];
    assign busy_o               = recover_cnt_ff != 32'h0000_0000;

    // ---------------- link clock domain ----------------
    // reset and bit order enter the link domain through two flops
    logic lsbf_meta_ff;
    logic lsbf_sync_ff;
    always_ff @(posedge sclk_i) begin
        rst_meta_ff  <= link_rst_req;
        rst_sync_ff  <= rst_meta_ff;
        lsbf_meta_ff <= interface_config_ff[SCP_BIT_LSBF_LO];
        lsbf_sync_ff <= lsbf_meta_ff;
    end

    typedef enum logic [1:0] {
        SCP_ST_INSTR,
        SCP_ST_WDATA,
        SCP_ST_RDATA
    } scp_state_t;

    scp_state_t  state_ff;
    logic [15:0] shift_ff;
    logic [4:0]  bit_cnt_ff;
    logic [14:0] addr_ff;
    logic [7:0]  rd_shift_ff;

    // read data: output mode byte and config byte are readable, others read zero
    logic [7:0] rd_byte;
    always_comb begin
        rd_byte = 8'h00;
        if (addr_ff == SCP_ADDR_IFCFG) begin
            rd_byte = interface_config_ff;
        end else if (addr_ff == SCP_ADDR_OUTMODE) begin
            rd_byte = output_format_mode_ff;
        end
    end

    logic [15:0] shift_in;
    assign shift_in = lsbf_sync_ff ? {sdio_i, shift_ff[15:1]} : {shift_ff[14:0], sdio_i};  // [R10]

    // set while select is high, cleared by the first sclk of the next frame
    logic frame_gap_ff;
    always_ff @(posedge sclk_i or posedge port_select_n_i) begin
        if (port_select_n_i) begin
            frame_gap_ff <= 1'b1;
        end else begin
            frame_gap_ff <= 1'b0;
        end
    end

    // a stall is kept only between the two instruction bytes; any other gap starts a new frame
    logic        stall_resume;
    logic        frame_restart;
    logic        shift_en;
    logic        instr_done;
    logic        byte_done;
    logic        instr_rd;
    logic [14:0] instr_addr;
    logic [7:0]  wr_byte;
    assign stall_resume  = (state_ff == SCP_ST_INSTR) && (bit_cnt_ff == 5'(SCP_BYTE_BITS));  // [R5]
    assign frame_restart = frame_gap_ff && !stall_resume;                                    // [R3]
    assign shift_en      = !port_select_n_i;                                                 // [R2]
    assign instr_done    = !frame_restart && (state_ff == SCP_ST_INSTR)
                           && (bit_cnt_ff == 5'(SCP_INSTR_BITS - 1));
    assign byte_done     = !frame_restart && (state_ff != SCP_ST_INSTR)
                           && (bit_cnt_ff == 5'(SCP_BYTE_BITS - 1));                        // [R7]
    assign instr_rd      = lsbf_sync_ff ? shift_in[0] : shift_in[15];                        // [R8]
    assign instr_addr    = lsbf_sync_ff ? shift_in[15:1] : shift_in[14:0];                   // [R20]
    assign wr_byte       = lsbf_sync_ff ? shift_in[15:8] : shift_in[7:0];                    // [R10]

    scp_state_t nxt_state;
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            SCP_ST_INSTR: begin
                if (instr_done) begin
                    nxt_state = instr_rd ? SCP_ST_RDATA : SCP_ST_WDATA;    // [R8]
                end
            end
            SCP_ST_WDATA: begin
                nxt_state = SCP_ST_WDATA;                                  // [R4]
            end
            SCP_ST_RDATA: begin
                nxt_state = SCP_ST_RDATA;                                  // [R4]
            end
            default: begin
                nxt_state = SCP_ST_INSTR;
            end
        endcase
        if (frame_restart) begin
            nxt_state = SCP_ST_INSTR;                                      // [R3]
        end
    end

    always_ff @(posedge sclk_i) begin
        if (rst_sync_ff) begin
            state_ff <= SCP_ST_INSTR;
        end else if (shift_en) begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge sclk_i) begin
        if (rst_sync_ff) begin
            bit_cnt_ff <= 5'h00;
        end else if (shift_en) begin
            if (frame_restart) begin
                bit_cnt_ff <= 5'h01;
            end else if (instr_done || byte_done) begin
                bit_cnt_ff <= 5'h00;
            end else begin
                bit_cnt_ff <= bit_cnt_ff + 5'h01;
            end
        end
    end

    always_ff @(posedge sclk_i) begin
        if (rst_sync_ff) begin
            shift_ff <= 16'h0000;
        end else if (shift_en) begin
            shift_ff <= shift_in;
        end
    end

    always_ff @(posedge sclk_i) begin
        if (rst_sync_ff) begin
            addr_ff <= 15'h0000;
        end else if (shift_en) begin
            if (instr_done) begin
                addr_ff <= instr_addr;                                     // [R20]
            end else if (byte_done) begin
                addr_ff <= addr_ff + 15'h0001;                             // [R4] [R20]
            end
        end
    end

    // address and data stay put until the next toggle, so the system side reads them safely
    always_ff @(posedge sclk_i) begin
        if (rst_sync_ff) begin
            wr_tgl_ff  <= 1'b0;
            wr_addr_ff <= 15'h0000;
            wr_data_ff <= 8'h00;
        end else if (shift_en && byte_done && state_ff == SCP_ST_WDATA) begin
            wr_addr_ff <= addr_ff;
            wr_data_ff <= wr_byte;
            wr_tgl_ff  <= ~wr_tgl_ff;
        end
    end

    // read byte launched on falling sclk so master samples on rising edge
    logic read_phase;
    assign read_phase = (state_ff == SCP_ST_RDATA) && !port_select_n_i;     // [R9]

    logic drive_ff;
    always_ff @(negedge sclk_i) begin
        if (rst_sync_ff) begin
            drive_ff <= 1'b0;
        end else begin
            drive_ff <= read_phase;
        end
    end

    logic       sdio_o_ff;
    logic [7:0] nxt_rd_shift;
    logic       nxt_sdio_o;
    always_comb begin
        nxt_rd_shift = rd_shift_ff;
        nxt_sdio_o   = sdio_o_ff;
        if (bit_cnt_ff == 5'h00) begin
            nxt_rd_shift = lsbf_sync_ff ? {1'b0, rd_byte[7:1]} : {rd_byte[6:0], 1'b0};
            nxt_sdio_o   = lsbf_sync_ff ? rd_byte[0] : rd_byte[7];         // [R10] [R18]
        end else begin
            nxt_rd_shift = lsbf_sync_ff ? {1'b0, rd_shift_ff[7:1]} : {rd_shift_ff[6:0], 1'b0};
            nxt_sdio_o   = lsbf_sync_ff ? rd_shift_ff[0] : rd_shift_ff[7];
        end
    end

    always_ff @(negedge sclk_i) begin
        if (rst_sync_ff) begin
            rd_shift_ff <= 8'h00;
            sdio_o_ff   <= 1'b0;
        end else if (read_phase) begin
            rd_shift_ff <= nxt_rd_shift;
            sdio_o_ff   <= nxt_sdio_o;
        end
    end

    assign sdio_o      = sdio_o_ff;
    // select high releases the line at once; a new frame never drives before its instruction
    assign sdio_oe_n_o = !(drive_ff && !frame_gap_ff && read_phase);       // [R1] [R6] [R11]
endmodule : scp_port

// ==== test/scp_port_assertions.sv ====
// checker for the serial configuration port
`timescale 1ns/1ps
module scp_port_assertions
    import scp_pkg::*;
#(parameter int RECOVER_CYC = SCP_RECOVER_CYC) (
    input wire logic       clk_i,
    input wire logic       sys_rst_i,
    input wire logic       sclk_i,
    input wire logic       port_select_n_i,
    input wire logic       sdio_i,
    input wire logic       sdio_o,
    input wire logic       sdio_oe_n_o,
    input wire logic [7:0] output_format_mode_o,
    input wire logic       lsb_first_o,
    input wire logic       busy_o
);
    int busy_cnt_ff;
    always_ff @(posedge clk_i) begin
        busy_cnt_ff <= (sys_rst_i || !busy_o) ? 0 : busy_cnt_ff + 1;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    sel_idle_hiz_a: assert property (port_select_n_i && $past(port_select_n_i) |-> sdio_oe_n_o)
        else $error("line driven");
    rst_mode_a: assert property ($past(sys_rst_i) |-> output_format_mode_o == SCP_OUTMODE_RST)
        else $error("mode default");
    rst_flags_a: assert property ($past(sys_rst_i) |-> !lsb_first_o && !busy_o && sdio_oe_n_o)
        else $error("flag default");
    busy_len_a: assert property ($fell(busy_o) |-> busy_cnt_ff == RECOVER_CYC)
        else $error("recovery length");
    busy_defaults_a: assert property (busy_o && $past(busy_o) |-> output_format_mode_o == 8'h01 && !lsb_first_o)
        else $error("soft defaults");
    busy_no_drive_a: assert property (busy_o |-> sdio_oe_n_o)
        else $error("drive in recovery");
    quiet_hold_a: assert property (port_select_n_i [*8] |=> $stable(output_format_mode_o) && $stable(lsb_first_o))
        else $error("change while idle");
    read_start_a: assert property ($fell(sdio_oe_n_o) |-> !port_select_n_i && !busy_o)
        else $error("turnaround");
endmodule : scp_port_assertions
bind scp_port scp_port_assertions #(.RECOVER_CYC(RECOVER_CYC)) u_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .sclk_i(sclk_i), .port_select_n_i(port_select_n_i), .sdio_i(sdio_i), .sdio_o(sdio_o), .sdio_oe_n_o(sdio_oe_n_o),
    .output_format_mode_o(output_format_mode_o), .lsb_first_o(lsb_first_o), .busy_o(busy_o));

// ==== test/scp_master_model.sv ====
// master side model driving the three-wire port
`timescale 1ns/1ps
module scp_master_model (
    output logic     sclk_o,
    output logic     sel_n_o,
    output logic     line_o,
    input wire logic sdio_i,
    input wire logic oe_n_i
);
    logic drv = 1'b0;
    logic lsbf = 1'b0;
    assign line_o = oe_n_i ? drv : sdio_i;
    initial begin
        sclk_o = 1'b0; // idles low outside frames
        sel_n_o = 1'b1;
    end
    task automatic pulse(input int n);
        repeat (n) begin
            #7.5 sclk_o = 1'b1;
            #7.5 sclk_o = 1'b0;
        end
    endtask : pulse
    task automatic sh(input logic [15:0] v, input int nb, input logic rd, output logic [15:0] r);
        int k;
        r = '0;
        for (int i = 0; i < nb; i++) begin
            k = lsbf ? i : nb - 1 - i;
            drv = rd ? ~drv : v[k]; // released line toggles
            #7.5 sclk_o = 1'b1;
            r[k] = line_o;
            #7.5 sclk_o = 1'b0;
        end
    endtask : sh
    task automatic op(input logic rd, input logic [14:0] a, input logic [7:0] w0, w1, input int n, input bit st,
                      output logic [7:0] r0, r1);
        logic [15:0] r;
        logic [15:0] iv;
        iv = lsbf ? {a, rd} : {rd, a}; // direction bit always first
        sel_n_o = 1'b0;
        if (st) begin
            sh({8'h00, lsbf ? iv[7:0] : iv[15:8]}, 8, 1'b0, r);
            sel_n_o = 1'b1; // stall between instruction bytes
            #60 sel_n_o = 1'b0;
            sh({8'h00, lsbf ? iv[15:8] : iv[7:0]}, 8, 1'b0, r);
        end else begin
            sh(iv, 16, 1'b0, r);
        end
        sh({8'h00, w0}, 8, rd, r);
        r0 = r[7:0];
        if (n > 1) sh({8'h00, w1}, 8, rd, r);
        r1 = r[7:0];
        #7.5 sel_n_o = 1'b1;
        #120;
    endtask : op
endmodule : scp_master_model

// ==== test/tb_scp_port.sv ====
// self-checking bench for the serial configuration port
`timescale 1ns/1ps
`define CHK(a, e, m) begin tests_run++; if ((a) !== (e)) begin err_total++; $display("Error %0t %s", $time, m); end end
module tb_scp_port;
    import scp_pkg::*;
    logic       clk_i = 1'b0;
    logic       sys_rst_i = 1'b1;
    logic       sclk, sel_n, line, sdo, oe_n, lsb, busy;
    logic [7:0] mode, r0, r1;
    int         err_total = 0;
    int         tests_run = 0;
    always #12.5 clk_i = ~clk_i;
    scp_port #(.RECOVER_CYC(20)) dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .sclk_i(sclk), .port_select_n_i(sel_n),
        .sdio_i(line), .sdio_o(sdo), .sdio_oe_n_o(oe_n), .output_format_mode_o(mode), .lsb_first_o(lsb), .busy_o(busy));
    scp_master_model m (.sclk_o(sclk), .sel_n_o(sel_n), .line_o(line), .sdio_i(sdo), .oe_n_i(oe_n));
    task automatic t_reset();
        `CHK({lsb, busy, oe_n}, 3'b001, "flags after reset")
        `CHK(mode, SCP_OUTMODE_RST, "mode after reset")
        m.op(1'b1, SCP_ADDR_OUTMODE, 8'h00, 8'h00, 1, 1'b0, r0, r1);
        `CHK(r0, SCP_OUTMODE_RST, "mode readback")
        $display("done reset");
    endtask : t_reset
    task automatic t_stream();
        m.op(1'b0, SCP_ADDR_OUTMODE, 8'h03, 8'h00, 1, 1'b1, r0, r1);
        `CHK(mode, 8'h03, "stalled write")
        m.op(1'b1, SCP_ADDR_OUTMODE - 15'h0001, 8'h00, 8'h00, 2, 1'b0, r0, r1); // read only
        `CHK(r0, 8'h00, "unmapped read")
        `CHK(r1, 8'h03, "streamed read")
        $display("done stream");
    endtask : t_stream
    task automatic t_order();
        m.op(1'b0, SCP_ADDR_IFCFG, 8'h40, 8'h00, 1, 1'b0, r0, r1);
        `CHK(lsb, 1'b1, "lsb first set")
        m.pulse(3);
        m.lsbf = 1'b1;
        m.op(1'b1, SCP_ADDR_IFCFG, 8'h00, 8'h00, 1, 1'b0, r0, r1);
        `CHK(r0, 8'h42, "mirrored order bits")
        m.op(1'b0, SCP_ADDR_IFCFG, 8'h00, 8'h00, 1, 1'b0, r0, r1);
        `CHK(lsb, 1'b0, "msb first again")
        m.pulse(3);
        m.lsbf = 1'b0;
        $display("done order");
    endtask : t_order
    task automatic t_soft();
        int k;
        m.op(1'b0, SCP_ADDR_IFCFG, SCP_SOFT_RST_VAL, 8'h00, 1, 1'b0, r0, r1);
        `CHK(busy, 1'b1, "recovery busy")
        for (k = 0; k < 40 && busy === 1'b1; k++) begin
            @(posedge clk_i);
            #1;
        end
        `CHK({busy, mode}, {1'b0, SCP_OUTMODE_RST}, "soft reset defaults")
        $display("done soft");
    endtask : t_soft
    task automatic print_verdict();
        $display("checks %0d errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : print_verdict
    initial begin
        fork
            m.pulse(3);
        join_none
        repeat (3) @(posedge clk_i);
        #1 sys_rst_i = 1'b0;
        m.pulse(3);
        repeat (2) @(posedge clk_i);
        #1;
        t_reset();
        t_stream();
        t_order();
        t_soft();
        print_verdict();
    end
    initial begin
        #100000;
        err_total++;
        print_verdict();
    end
endmodule : tb_scp_port
